// ---- dv/fula_core_monitor.sv ----
// fula_core_monitor: port checks of fula_core
// assumes binding onto fula_core
`timescale 1ns/100ps
`default_nettype none
// ---
// checker
// ---
module fula_core_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire fula_pkg::fula_req_t req,
  input wire fula_pkg::fula_rsp_t rsp
);
  import fula_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // small positive operands, small exponents, 64-bit
  wire logic sm = !req.fmt32 && req.a[63:56] == 8'h00 &&
    req.b[63:56] == 8'h00 && req.a[47:46] == 2'b00 && req.b[47:46] == 2'b00;
  wire logic add = req.valid && req.op == FULA_ADD && sm &&
    req.a[63:48] == req.b[63:48];
  wire logic mul = req.valid && req.op == FULA_MUL && sm;
  AST_VALID: assert property (req.valid |=> rsp.valid)
    else $error("no result pulse");
  AST_PULSE: assert property (!req.valid |=> !rsp.valid)
    else $error("result pulse without request");
  AST_HOLD: assert property (!rsp.valid |->
    $stable(rsp.up) && $stable(rsp.lo))
    else $error("result words moved");
  AST_LOSIGN: assert property (rsp.valid |-> !rsp.lo[47])
    else $error("lower sign set");
  AST_ADD_EXP: assert property (add |=>
    rsp.up[63:48] == $past(req.a[63:48])
    && rsp.lo[63:48] == $past(req.a[63:48]) - 16'd47)
    else $error("add exponent wrong");
  AST_ADD_COEF: assert property (add |=>
    rsp.lo[46:0] == 47'h0 &&
    rsp.up[47:0] == $past(req.a[47:0]) + $past(req.b[47:0]))
    else $error("add coefficient wrong");
  AST_MUL_LO: assert property (mul |=>
    rsp.lo[63:48] == $past(req.a[63:48]) + $past(req.b[63:48]))
    else $error("mul lower exponent wrong");
  AST_MUL_UP: assert property (mul |=>
    rsp.up[63:48] == $past(req.a[63:48]) + $past(req.b[63:48]) + 16'd47)
    else $error("mul upper exponent wrong");
  AST_IND: assert property (req.valid && req.op == FULA_ADD &&
    !req.fmt32 && req.a[63:60] == 4'h7
    |=> {rsp.up[63:60], rsp.lo[63:60]} == 8'h77)
    else $error("indefinite lost");
  AST_MUL_ZERO: assert property (req.valid && req.op == FULA_MUL &&
    !req.fmt32 && req.b[63:60] == 4'h8 && req.a[63:60] != 4'h7
    |=> rsp.up[63:60] == 4'h8)
    else $error("machine zero lost");
  cover property (mul);
  cover property (req.valid && req.op == FULA_ACC && !req.acc_start);
  cover property (req.valid && req.op == FULA_DIV);
  cover property (rsp.valid && rsp.uf.ovf);
endmodule
bind fula_core fula_core_monitor u_mon (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .req(req),
  .rsp(rsp)
);
`default_nettype wire

// ---- dv/fula_core_tb.sv ----
// fula_core_tb: random and corner tests of fula_core
// assumes the monitor is bound and the model captures results
`timescale 1ns/100ps
`default_nettype none
module fula_core_tb;
  import fula_pkg::*;
  logic core_clk, rst_n;
  fula_req_t req;
  fula_rsp_t rsp, last;
  int errors = 0, n_compared = 0, cyc = 0;
  logic [31:0] r;
  logic [15:0] e, f;
  logic [47:0] ca, cb, sh;
  logic [95:0] p;
  fula_core uut (.core_clk(core_clk), .rst_n(rst_n), .req(req), .rsp(rsp));
  fula_regfile_model mdl (.core_clk(core_clk), .rst_n(rst_n), .rsp(rsp),
    .last(last));
  // ---
  // helpers
  // ---
  function logic [95:0] pr(input logic [47:0] x, y);
    return 96'($signed(x)) * 96'($signed(y));
  endfunction
  task stop_test;
    if (errors == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [63:0] g, x);
    n_compared++;
    if (g !== x) begin
      errors++;
      $display("[FAIL] %0t got %h want %h", $time, g, x);
    end
  endtask
  task run(input fula_op_t op, input logic f32, s, input logic [63:0] x, y);
    @(posedge core_clk);
    req <= '{1'b1, op, f32, s, x, y};
    @(posedge core_clk);
    req.valid <= 1'b0;
    #1 chk(64'(rsp.valid), 64'h1);
    @(posedge core_clk);
    #1 chk(64'(rsp.valid), 64'h0);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end
  // ---
  // main sequence
  // ---
  initial begin
    req = '0;
    rst_n = 1'b0;
    r = $urandom(53048);
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 30; i++) begin
      r = $urandom;
      e = 16'(r[7:0]);
      f = 16'(r[15:8]);
      r = $urandom;
      ca = 48'($signed(r[23:0]));
      r = $urandom;
      cb = 48'($signed(r[23:0]));
      sh = 48'($signed(cb) >>> 2);
      p = pr(ca, cb);
      case (i % 3)
        0: begin
          run(FULA_ADD, 1'b0, 1'b0, {e + 16'd2, ca}, {e, cb});
          chk(last.up, {e + 16'd2, ca + sh});
          chk(last.lo, {e - 16'd45, 1'b0, cb[1:0], 45'h0});
        end
        1: begin
          run(FULA_SUB, 1'b0, 1'b0, {e, ca}, {e, cb});
          chk(last.up, {e, ca - cb});
          chk(last.lo, {e - 16'd47, 48'h0});
        end
        default: begin
          run(FULA_MUL, 1'b0, 1'b0, {e, ca}, {f, cb});
          chk(last.up, {e + f + 16'd47, p[94:47]});
          chk(last.lo, {e + f, 1'b0, p[46:0]});
        end
      endcase
    end
    run(FULA_ADD, 1'b0, 1'b0, 64'h0005_0000_0000_0100, 64'h0005_0000_0000_0200);
    chk(last.up, 64'h0005_0000_0000_0300);
    run(FULA_ADD, 1'b0, 1'b0, 64'h0010_7fff_ffff_ffff, 64'h0010_7fff_ffff_ffff);
    chk(last.up, 64'h0011_7fff_ffff_ffff);
    chk(last.lo, {16'h0011 - 16'd47, 48'h0});
    run(FULA_ADD, 1'b0, 1'b0, 64'h6fff_7fff_ffff_ffff, 64'h6fff_7fff_ffff_ffff);
    chk(64'({last.up[63:60], last.lo[63:48]}), 64'h7_6fd1);
    chk(64'(last.uf.ovf), 64'h1);
    run(FULA_ADD, 1'b0, 1'b0, 64'h9000_0000_0000_0001, 64'h9000_0000_0000_0001);
    chk(64'({last.lo[63:60], last.lf.unf}), 64'h11);
    run(FULA_ADD, 1'b0, 1'b0, 64'h7000_0000_0000_0001, 64'h0000_0000_0000_0001);
    chk(64'({last.up[63:60], last.lo[63:60]}), 64'h77);
    run(FULA_MUL, 1'b0, 1'b0, 64'h0000_0000_0000_0003, 64'h8000_0000_0000_0001);
    chk(64'(last.up[63:60]), 64'h8);
    run(FULA_MUL, 1'b0, 1'b0, 64'h3800_0000_0000_0001, 64'h3800_0000_0000_0001);
    chk(64'(last.up[63:60]), 64'h7);
    chk(64'({last.lo[63:60], last.lf.ovf}), 64'hf);
    run(FULA_MUL, 1'b0, 1'b0, 64'hc000_0000_0000_0001, 64'hc000_0000_0000_0001);
    chk(64'(last.up[63:60]), 64'h8);
    chk(64'(last.uf.unf), 64'h1);
    run(FULA_MUL, 1'b0, 1'b0, 64'h0000_8000_0000_0000, 64'h0000_0000_0000_0001);
    chk(last.up, 64'h0030_ffff_ffff_ffff);
    run(FULA_DIV, 1'b0, 1'b0, 64'h0000_0000_0000_0064, 64'h0000_0000_0000_0004);
    chk(last.up, 64'hfffe_0000_0000_0064);
    chk(64'(last.lo[63:60]), 64'h8);
    run(FULA_ADDN, 1'b0, 1'b0, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0000);
    chk(last.up, 64'hffd2_4000_0000_0000);
    run(FULA_SUBN, 1'b0, 1'b0, 64'h0000_0000_0000_0002, 64'h0000_0000_0000_0001);
    chk(last.up, 64'hffd2_4000_0000_0000);
    run(FULA_ADD, 1'b1, 1'b0, 64'h0500_0010, 64'h0500_0020);
    chk(last.up, 64'h0500_0030);
    chk(last.lo, 64'hee00_0000);
    run(FULA_ACC, 1'b0, 1'b1, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0002);
    chk(last.up, 64'h0000_0000_0000_0001);
    chk(last.lo, 64'hffd1_0000_0000_0000);
    run(FULA_DOT, 1'b0, 1'b1, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0002);
    chk(last.up, 64'h002f_0000_0000_0000);
    chk(last.lo, 64'h0000_0000_0000_0002);
    run(FULA_ADD, 1'b0, 1'b0, 64'h0000_0000_0000_0005, 64'h0000_0000_0000_0005);
    chk(last.up, 64'h0000_0000_0000_000a);
    run(FULA_ACC, 1'b0, 1'b0, 64'h002f_0000_0000_0001, 64'h0);
    chk(last.up, 64'h002f_0000_0000_0001);
    chk(last.lo, 64'h0000_0000_0000_0002);
    stop_test();
  end
endmodule
`default_nettype wire

// ---- dv/fula_regfile_model.sv ----
// fula_regfile_model: result write-back side of the datapath
// assumes one rsp.valid pulse per accepted request
`timescale 1ns/100ps
`default_nettype none
// ---
// keeps the last written result pair
// ---
module fula_regfile_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire fula_pkg::fula_rsp_t rsp,
  output var fula_pkg::fula_rsp_t last
);
  import fula_pkg::*;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      last <= '0;
    end else if (rsp.valid) begin
      last <= rsp;
    end
  end
endmodule
`default_nettype wire

// ---- hdl/fula_consts.svh ----
// fula_consts.svh: widths and encodings of the upper/lower float datapath
// assumes nothing; included by the package and the core
`ifndef FULA_CONSTS_SVH
`define FULA_CONSTS_SVH

// ----------------------------------------------------------------------
// formats
// ----------------------------------------------------------------------
`define FULA_WORD_W 64
`define FULA_CW64 48
`define FULA_EW64 16
`define FULA_CW32 24
`define FULA_EW32 8
`define FULA_PC_W 95
`define FULA_PC32_W 47

// ----------------------------------------------------------------------
// exponent leading digits of special values
// ----------------------------------------------------------------------
`define FULA_NIB_IND 4'h7
`define FULA_NIB_ZERO 4'h8

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define FULA_PE_RST 16'h8000

`endif

// ---- hdl/fula_core.sv ----
// fula_core: float add/sub/mul/div with upper and lower results
// assumes issue logic presents one request per cycle, result one cycle on
`timescale 1ns/100ps
`default_nettype none
`include "fula_consts.svh"

// ----------------------------------------------------------------------
// one format's combinational datapath
// ----------------------------------------------------------------------
module fula_fmt #(
  parameter int CW = 48,
  parameter int EW = 16
) (
  input wire fula_pkg::fula_op_t op,
  input wire logic [EW+CW-1:0] a,
  input wire logic [EW+CW-1:0] b,
  input wire logic pz,
  input wire logic [2*CW-2:0] pc,
  input wire logic [EW-1:0] pe,
  output logic [EW+CW-1:0] u,
  output logic [EW+CW-1:0] l,
  output fula_pkg::fula_flags_t uf,
  output fula_pkg::fula_flags_t lf,
  output logic [2*CW-2:0] npc,
  output logic [EW-1:0] npe
);
  import fula_pkg::*;
  localparam int L = CW - 1;
  localparam int XW = 2 * L + 1;
  localparam int WE = EW + 2;
  localparam int FW = EW + CW;
  localparam int NB = $clog2(CW);
  localparam logic signed [WE-1:0] EMAX = WE'((7 << (EW - 4)) - 1);
  localparam logic signed [WE-1:0] EMIN = ~EMAX;
  localparam logic signed [WE-1:0] SL = WE'(L);
  localparam logic signed [WE-1:0] SL1 = WE'(L - 1);
  localparam logic [EW-1:0] EOVL = EW'(EMAX - SL1);
  localparam logic [FW-1:0] W_IND = {`FULA_NIB_IND, {(FW-4){1'b0}}};
  localparam logic [FW-1:0] W_ZERO = {`FULA_NIB_ZERO, {(FW-4){1'b0}}};
  localparam logic [CW-1:0] C_MIN = {1'b1, {L{1'b0}}};
  localparam logic [CW-1:0] C_FIX = {2'b11, {(CW-2){1'b0}}};

  function automatic logic signed [WE-1:0] wx(input logic [EW-1:0] e);
    return $signed({{2{e[EW-1]}}, e});
  endfunction

  // range check, returns {ovf, unf, word}
  function automatic logic [FW+1:0] fin(input logic signed [WE-1:0] e,
                                       input logic [CW-1:0] c);
    if (e > EMAX) return {2'b10, W_IND};
    else if (e < EMIN) return {2'b01, W_ZERO};
    else return {2'b00, e[EW-1:0], c};
  endfunction

  // left shift that brings sign and next bit apart
  function automatic logic [NB-1:0] lsc(input logic [CW-1:0] c);
    logic [NB-1:0] n;
    n = NB'(L);
    for (int i = 0; i < L; i++) begin
      if (c[i] != c[L]) n = NB'(L - 1 - i);
    end
    return n;
  endfunction

  logic [CW-1:0] ca, cb, cu, dvn;
  logic signed [WE-1:0] ea, eb, e1, e2, ehi, eu, es, eq;
  logic ia, ib, za, zb, i1, i2, z1, z2, rn;
  logic signed [XW-1:0] x1, x2, xs;
  logic signed [XW:0] sum;
  logic [XW-1:0] r;
  logic [WE-1:0] d;
  logic signed [2*CW-1:0] prod;
  logic signed [CW+L-2:0] num, den, quo;
  logic [NB-1:0] nc, ns;
  logic [FW+1:0] fu, fl;

  always_comb begin
    ca = a[CW-1:0];
    cb = b[CW-1:0];
    ia = a[FW-1 -: 4] == `FULA_NIB_IND;
    ib = b[FW-1 -: 4] == `FULA_NIB_IND;
    za = a[FW-1 -: 4] == `FULA_NIB_ZERO;
    zb = b[FW-1 -: 4] == `FULA_NIB_ZERO;
    ea = wx(a[FW-1:CW]);
    eb = wx(b[FW-1:CW]);
    // most-negative coefficient would overflow the product sign
    if (op inside {FULA_MUL, FULA_DIV, FULA_DOT}) begin
      if (ca == C_MIN) begin
        ca = C_FIX;
        ea = ea + WE'(1);
      end
      if (cb == C_MIN) begin
        cb = C_FIX;
        eb = eb + WE'(1);
      end
    end
    if (op inside {FULA_SUB, FULA_SUBN}) cb = -cb;
    prod = $signed(ca) * $signed(cb);
    es = ea + eb;
    // operands of the add path
    x1 = $signed({ca, {L{1'b0}}});
    x2 = $signed({cb, {L{1'b0}}});
    e1 = ea;
    e2 = eb;
    i1 = ia;
    i2 = ib;
    z1 = za;
    z2 = zb;
    if (op inside {FULA_ACC, FULA_DOT}) begin
      x1 = $signed(pc);
      e1 = wx(pe);
      i1 = !pz && pe[EW-1 -: 4] == `FULA_NIB_IND;
      z1 = pz || pe[EW-1 -: 4] == `FULA_NIB_ZERO;
      if (op == FULA_ACC) begin
        x2 = $signed({ca, {L{1'b0}}});
        e2 = ea;
        i2 = ia;
        z2 = za;
      end else begin
        x2 = prod[XW-1:0];
        e2 = es + SL;
        i2 = ia | ib;
        z2 = !i2 && (za | zb);
      end
    end
    // machine zero joins at the other operand's exponent
    if (z1) begin
      x1 = '0;
      e1 = e2;
    end
    if (z2) begin
      x2 = '0;
      e2 = e1;
    end
    // alignment of the smaller exponent
    ehi = (e1 >= e2) ? e1 : e2;
    d = (e1 >= e2) ? WE'(e1 - e2) : WE'(e2 - e1);
    xs = x2;
    if (e1 < e2) begin
      xs = x1;
      x1 = x2;
    end
    // both arms signed, or the shift would turn logical
    xs = (d >= WE'(XW)) ? $signed({XW{xs[XW-1]}}) : (xs >>> d);
    sum = {x1[XW-1], x1} + {xs[XW-1], xs};
    rn = sum[XW] ^ sum[XW-1];
    r = rn ? sum[XW:1] : sum[XW-1:0];
    eu = ehi + $signed({{(WE-1){1'b0}}, rn});
    cu = r[XW-1 -: CW];
    fu = fin(eu, cu);
    fl = fin(eu - SL, {1'b0, r[L-1:0]});
    if (fu[FW+1]) fl = {2'b00, EOVL, 1'b0, r[L-1:0]};
    ns = lsc(cu);
    if (op inside {FULA_ADDN, FULA_SUBN} && !fu[FW+1]) begin
      if (cu == '0) fu = {2'b00, W_ZERO};
      else fu = fin(eu - $signed({{(WE-NB){1'b0}}, ns}), cu << ns);
    end
    if (z1 && z2) begin
      fu = {2'b00, W_ZERO};
      fl = {2'b00, W_ZERO};
    end
    if (i1 || i2) begin
      fu = {2'b00, W_IND};
      fl = {2'b00, W_IND};
    end
    // divide path
    nc = lsc(cb);
    dvn = cb << nc;
    num = $signed({ca, {(L-1){1'b0}}});
    den = $signed({{(L-1){dvn[CW-1]}}, dvn});
    // zero divisor is forced indefinite below; keep the divider defined
    if (cb == '0) den = '1;
    quo = num / den;
    eq = ea - eb - (SL1 - $signed({{(WE-NB){1'b0}}, nc}));
    case (op)
      FULA_MUL: begin
        fu = fin(es + SL, prod[XW-1 -: CW]);
        fl = fin(es, {1'b0, prod[L-1:0]});
        if (ia || ib) begin
          fu = {2'b00, W_IND};
          fl = {2'b00, W_IND};
        end else if (za || zb) begin
          fu = {2'b00, W_ZERO};
          fl = {2'b00, W_ZERO};
        end
      end
      FULA_DIV: begin
        fu = fin(eq, quo[CW-1:0]);
        fl = {2'b00, W_ZERO};
        if (ia || ib || zb || cb == '0) fu = {2'b00, W_IND};
        else if (za) fu = {2'b00, W_ZERO};
      end
      default: begin
      end
    endcase
  end

  assign u = fu[FW-1:0];
  assign l = fl[FW-1:0];
  assign uf = fu[FW+1:FW];
  assign lf = fl[FW+1:FW];
  assign npc = r;
  assign npe = fu[FW-1:CW];
endmodule

// ----------------------------------------------------------------------
// top: format select and result register
// ----------------------------------------------------------------------
module fula_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire fula_pkg::fula_req_t req,
  output var fula_pkg::fula_rsp_t rsp
);
  import fula_pkg::*;
  fula_state_t st, next_st;
  logic [63:0] u64, l64;
  logic [31:0] u32, l32;
  fula_flags_t uf64, lf64, uf32, lf32;
  logic [`FULA_PC_W-1:0] npc64;
  logic [`FULA_PC32_W-1:0] npc32;
  logic [`FULA_EW64-1:0] npe64;
  logic [`FULA_EW32-1:0] npe32;

  fula_fmt #(.CW(`FULA_CW64), .EW(`FULA_EW64)) u_f64 (
    .op(req.op), .a(req.a), .b(req.b), .pz(req.acc_start),
    .pc(st.pc), .pe(st.pe), .u(u64), .l(l64), .uf(uf64), .lf(lf64),
    .npc(npc64), .npe(npe64)
  );

  // 32-bit lane sees the low half-word only
  fula_fmt #(.CW(`FULA_CW32), .EW(`FULA_EW32)) u_f32 (
    .op(req.op), .a(req.a[31:0]), .b(req.b[31:0]), .pz(req.acc_start),
    .pc(st.pc[`FULA_PC32_W-1:0]), .pe(st.pe[`FULA_EW32-1:0]),
    .u(u32), .l(l32), .uf(uf32), .lf(lf32), .npc(npc32), .npe(npe32)
  );

  always_comb begin
    next_st = st;
    next_st.rsp.valid = req.valid;
    if (req.valid) begin
      if (req.fmt32) begin
        next_st.rsp.up = {32'h0, u32};
        next_st.rsp.lo = {32'h0, l32};
        next_st.rsp.uf = uf32;
        next_st.rsp.lf = lf32;
      end else begin
        next_st.rsp.up = u64;
        next_st.rsp.lo = l64;
        next_st.rsp.uf = uf64;
        next_st.rsp.lf = lf64;
      end
      // partial sum moves only on accumulate requests
      if (req.op inside {FULA_ACC, FULA_DOT}) begin
        if (req.fmt32) begin
          next_st.pc = {48'h0, npc32};
          next_st.pe = {8'h0, npe32};
        end else begin
          next_st.pc = npc64;
          next_st.pe = npe64;
        end
      end
    end
  end

  // partial sum restarts as machine zero after reset in the 64-bit lane; the 32-bit lane sees coefficient 0 at exponent 0
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st.rsp <= '0;
      st.pc <= '0;
      st.pe <= `FULA_PE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign rsp = st.rsp;
endmodule
`default_nettype wire

// ---- hdl/fula_pkg.sv ----
// fula_pkg: types of the upper/lower float datapath
// assumes fula_consts.svh on the include path
`include "fula_consts.svh"

package fula_pkg;
  typedef enum logic [2:0] {
    FULA_ADD, FULA_SUB, FULA_ADDN, FULA_SUBN,
    FULA_MUL, FULA_DIV, FULA_ACC, FULA_DOT
  } fula_op_t;

  typedef struct packed {
    logic ovf;
    logic unf;
  } fula_flags_t;

  typedef struct packed {
    logic valid;
    fula_op_t op;
    logic fmt32;
    logic acc_start;
    logic [`FULA_WORD_W-1:0] a;
    logic [`FULA_WORD_W-1:0] b;
  } fula_req_t;

  typedef struct packed {
    logic valid;
    logic [`FULA_WORD_W-1:0] up;
    logic [`FULA_WORD_W-1:0] lo;
    fula_flags_t uf;
    fula_flags_t lf;
  } fula_rsp_t;

  typedef struct packed {
    fula_rsp_t rsp;
    logic [`FULA_PC_W-1:0] pc;
    logic [`FULA_EW64-1:0] pe;
  } fula_state_t;
endpackage
